//--- inc/dfrs_pkg.sv
// Shared constants and types for the double-rate fast read sequencer.
// Assumes a 32-bit APB register port and a single-bit serial flash link.
package dfrs_pkg;

    // ----------------------------------------------------------------
    // Command codes and phase lengths
    // ----------------------------------------------------------------
    localparam logic [7:0] CMD_DOUBLE_RATE_READ = 8'h0D;
    localparam logic [7:0] CMD_DOUBLE_RATE_READ_WIDE = 8'h0E;
    localparam logic [5:0] INSTR_BITS = 6'h08;
    localparam logic [5:0] ADDR_BITS_NARROW = 6'h18;
    localparam logic [5:0] ADDR_BITS_WIDE = 6'h20;
    localparam logic [5:0] MODE_EDGES = 6'h08;
    localparam logic [5:0] PRE_EDGES = 6'h08;
    localparam logic [3:0] LC_DUMMY_BASE = 4'h1;

    // ----------------------------------------------------------------
    // Memory array
    // ----------------------------------------------------------------
    localparam int MEM_AW = 8;
    localparam int MEM_DEPTH = 256;
    localparam logic [31:0] ADDR_TOP = 32'h0000_00FF;

    // ----------------------------------------------------------------
    // Register map and reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_CONFIG = 8'h00;
    localparam logic [7:0] REG_PATTERN = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_ADDR = 8'h0C;
    localparam logic [7:0] REG_MEM_PTR = 8'h10;
    localparam logic [7:0] REG_MEM_DATA = 8'h14;
    localparam logic [7:0] PATTERN_RESET = 8'h34;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_INSTR = 3'b001,
        ST_ADDR = 3'b010,
        ST_MODE = 3'b011,
        ST_DUMMY = 3'b100,
        ST_DATA = 3'b101,
        ST_IGNORE = 3'b110
    } dfrs_state_e;

    // Layout of config_register_one, high bit first
    typedef struct packed {
        logic [3:0] latency_code_field;
        logic preamble_en;
        logic enhanced_latency_table;
        logic wide_address_select;
    } dfrs_cfg_s;

    localparam dfrs_cfg_s CFG_RESET = '0;

    typedef struct packed {
        logic [7:0] mode_bits;
        dfrs_state_e state;
        logic driving;
        logic busy;
        logic cont_mode;
    } dfrs_status_s;

endpackage

//--- core/dfrs_core.sv
// Device side of the single-bit double-data-rate fast read on a serial flash.
// Assumes CS#, SCK, SI and HOLD# are asynchronous pins and SCK is far slower than clk_sys.
`timescale 1ns/1ps

module dfrs_core
    import dfrs_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // Serial flash pins
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic hold_n,
    output logic so_out,
    output logic so_oe_n,
    output logic hold_pause
);

    // ----------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ----------------------------------------------------------------
    logic [3:0] pin_s1_q;
    logic [3:0] pin_s2_q;
    logic sck_s3_q;
    logic cs_s3_q;
    logic cs_s;
    logic sck_s;
    logic si_s;
    logic hold_s;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pin_s1_q <= 4'hF;
            pin_s2_q <= 4'hF;
            sck_s3_q <= 1'b1;
            cs_s3_q <= 1'b1;
        end else begin
            pin_s1_q <= {cs_n, sck, si, hold_n};
            pin_s2_q <= pin_s1_q;
            sck_s3_q <= pin_s2_q[2];
            cs_s3_q <= pin_s2_q[3];
        end
    end

    assign cs_s = pin_s2_q[3];
    assign sck_s = pin_s2_q[2];
    assign si_s = pin_s2_q[1];
    assign hold_s = pin_s2_q[0];

    logic cs_fall;
    logic cs_rise;
    logic rise_act;
    logic fall_act;
    logic edge_act;

    assign cs_fall = !cs_s && cs_s3_q;
    assign cs_rise = cs_s && !cs_s3_q;
    assign rise_act = !cs_s && sck_s && !sck_s3_q;
    assign fall_act = !cs_s && !sck_s && sck_s3_q;
    assign edge_act = rise_act || fall_act;

    // ----------------------------------------------------------------
    // Registers and memory array
    // ----------------------------------------------------------------
    dfrs_cfg_s cfg_q;
    logic [7:0] pattern_q;
    logic [MEM_AW-1:0] mem_ptr_q;
    logic [7:0] mem [MEM_DEPTH];

    dfrs_state_e state_q;
    logic [5:0] bit_cnt_q;
    logic [5:0] addr_len_q;
    logic [31:0] sh_q;
    logic [31:0] addr_q;
    logic [7:0] mode_q;
    logic mode_done_q;
    logic need_rise_q;
    logic cont_q;
    logic so_q;
    logic drive_q;
    logic hold_pause_q;

    // ----------------------------------------------------------------
    // Sequencer decode
    // ----------------------------------------------------------------
    logic [7:0] cmd_word;
    logic [31:0] addr_word;
    logic [5:0] dummy_edges;
    logic [7:0] rd_byte;
    logic instr_done;
    logic addr_edge;
    logic addr_done;
    logic mode_done;
    logic dummy_edge;
    logic dummy_done;
    logic data_edge;
    logic launch_pre;
    logic [2:0] pre_pos;
    logic busy;
    logic mode_comp;

    assign cmd_word = {sh_q[6:0], si_s};
    assign addr_word = {sh_q[30:0], si_s};
    // Latency tables live outside; the code maps linearly to cycles
    assign dummy_edges = {5'({1'b0, cfg_q.latency_code_field} + {1'b0, LC_DUMMY_BASE}), 1'b0};
    assign rd_byte = mem[addr_q[MEM_AW-1:0]];
    assign instr_done = (state_q == ST_INSTR) && rise_act && (bit_cnt_q == INSTR_BITS - 6'h01);
    // The falling edge right after the last instruction bit belongs to no phase
    assign addr_edge = (state_q == ST_ADDR) && (rise_act || (fall_act && !need_rise_q));
    assign addr_done = addr_edge && (bit_cnt_q == addr_len_q - 6'h01);
    assign mode_done = (state_q == ST_MODE) && edge_act && (bit_cnt_q == MODE_EDGES - 6'h01);
    assign dummy_edge = (state_q == ST_DUMMY) && edge_act;
    assign dummy_done = dummy_edge && (bit_cnt_q == dummy_edges - 6'h01);
    assign data_edge = (state_q == ST_DATA) && edge_act;
    assign launch_pre = dummy_edge && cfg_q.preamble_en
        && ({1'b0, bit_cnt_q} + {1'b0, PRE_EDGES} >= {1'b0, dummy_edges});
    assign pre_pos = 3'(bit_cnt_q + PRE_EDGES - dummy_edges);
    assign busy = (state_q != ST_IDLE) && (state_q != ST_IGNORE);
    assign mode_comp = (mode_q[7:4] == ~mode_q[3:0]);

    // ----------------------------------------------------------------
    // Phase sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ST_IDLE;
            bit_cnt_q <= 6'h00;
            need_rise_q <= 1'b0;
            sh_q <= 32'h0000_0000;
        end else if (cs_s) begin
            state_q <= ST_IDLE;
            bit_cnt_q <= 6'h00;
        end else if (cs_fall) begin
            state_q <= cont_q ? ST_ADDR : ST_INSTR;
            bit_cnt_q <= 6'h00;
            need_rise_q <= 1'b1;
        end else begin
            case (state_q)
                ST_INSTR: begin
                    if (rise_act) begin
                        sh_q <= addr_word;
                        bit_cnt_q <= bit_cnt_q + 6'h01;
                    end
                    if (instr_done) begin
                        bit_cnt_q <= 6'h00;
                        if (cmd_word == CMD_DOUBLE_RATE_READ || cmd_word == CMD_DOUBLE_RATE_READ_WIDE) begin
                            state_q <= ST_ADDR;
                        end else begin
                            state_q <= ST_IGNORE;
                        end
                    end
                end
                ST_ADDR: begin
                    if (addr_edge) begin
                        need_rise_q <= 1'b0;
                        sh_q <= addr_word;
                        bit_cnt_q <= bit_cnt_q + 6'h01;
                    end
                    if (addr_done) begin
                        bit_cnt_q <= 6'h00;
                        state_q <= cfg_q.enhanced_latency_table ? ST_MODE : ST_DUMMY;
                    end
                end
                ST_MODE: begin
                    if (edge_act) begin
                        sh_q <= addr_word;
                        bit_cnt_q <= bit_cnt_q + 6'h01;
                    end
                    if (mode_done) begin
                        bit_cnt_q <= 6'h00;
                        state_q <= ST_DUMMY;
                    end
                end
                ST_DUMMY: begin
                    if (dummy_edge) begin
                        bit_cnt_q <= bit_cnt_q + 6'h01;
                    end
                    if (dummy_done) begin
                        bit_cnt_q <= 6'h00;
                        state_q <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (data_edge) begin
                        bit_cnt_q <= {3'b000, bit_cnt_q[2:0] + 3'b001};
                    end
                end
                ST_IGNORE: begin
                    state_q <= ST_IGNORE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Address length, address counter and mode capture
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            addr_len_q <= ADDR_BITS_NARROW;
        end else if (instr_done) begin
            if (cmd_word == CMD_DOUBLE_RATE_READ_WIDE) begin
                addr_len_q <= ADDR_BITS_WIDE;
            end else begin
                addr_len_q <= cfg_q.wide_address_select ? ADDR_BITS_WIDE : ADDR_BITS_NARROW;
            end
        end
    end

    // Only the low address bits reach the array; upper bits fold back in
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            addr_q <= 32'h0000_0000;
        end else if (addr_done) begin
            addr_q <= addr_word & ADDR_TOP;
        end else if (data_edge && bit_cnt_q[2:0] == 3'b111) begin
            addr_q <= (addr_q == ADDR_TOP) ? 32'h0000_0000 : addr_q + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            mode_q <= 8'h00;
            mode_done_q <= 1'b0;
        end else if (cs_fall) begin
            mode_done_q <= 1'b0;
        end else if (mode_done) begin
            mode_q <= cmd_word;
            mode_done_q <= 1'b1;
        end
    end

    // A frame cut short before its mode bits are whole counts as an exit
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cont_q <= 1'b0;
        end else if (cs_rise) begin
            cont_q <= mode_done_q && mode_comp;
        end
    end

    // ----------------------------------------------------------------
    // SO driver: preamble, then data on every edge
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            so_q <= 1'b0;
            drive_q <= 1'b0;
        end else if (cs_s) begin
            drive_q <= 1'b0;
        end else if (launch_pre) begin
            so_q <= pattern_q[~pre_pos];
            drive_q <= 1'b1;
        end else if (data_edge) begin
            so_q <= rd_byte[~bit_cnt_q[2:0]];
            drive_q <= 1'b1;
        end
    end

    assign so_out = so_q;
    assign so_oe_n = !drive_q;

    // ----------------------------------------------------------------
    // Hold pause, blocked while a double-rate read runs
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            hold_pause_q <= 1'b0;
        end else begin
            hold_pause_q <= !hold_s && !busy;
        end
    end

    assign hold_pause = hold_pause_q;

    // ----------------------------------------------------------------
    // APB slave, zero wait states
    // ----------------------------------------------------------------
    logic apb_setup;
    logic apb_access;
    logic apb_hit;
    logic wr_en;
    dfrs_status_s status;
    logic [31:0] rd_mux;

    assign apb_setup = psel && !penable;
    assign apb_access = psel && penable;
    assign apb_hit = (paddr == REG_CONFIG) || (paddr == REG_PATTERN) || (paddr == REG_STATUS)
        || (paddr == REG_ADDR) || (paddr == REG_MEM_PTR) || (paddr == REG_MEM_DATA);
    assign wr_en = apb_access && pwrite && pstrb[0];
    assign pready = 1'b1;
    assign pslverr = apb_access && !apb_hit;
    assign status = '{mode_bits: mode_q, state: state_q, driving: drive_q, busy: busy, cont_mode: cont_q};

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            REG_CONFIG: rd_mux = 32'(cfg_q);
            REG_PATTERN: rd_mux = 32'(pattern_q);
            REG_STATUS: rd_mux = 32'(status);
            REG_ADDR: rd_mux = addr_q;
            REG_MEM_PTR: rd_mux = 32'(mem_ptr_q);
            REG_MEM_DATA: rd_mux = 32'(mem[mem_ptr_q]);
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            prdata <= 32'h0000_0000;
        end else if (apb_setup) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_mux;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cfg_q <= CFG_RESET;
            pattern_q <= PATTERN_RESET;
        end else if (wr_en && paddr == REG_CONFIG) begin
            cfg_q <= pwdata[$bits(dfrs_cfg_s)-1:0];
        end else if (wr_en && paddr == REG_PATTERN) begin
            pattern_q <= pwdata[7:0];
        end
    end

    // Pointer steps after each data read and each data write with pstrb[0] set, so the array streams in or out
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            mem_ptr_q <= '0;
        end else if (wr_en && paddr == REG_MEM_PTR) begin
            mem_ptr_q <= pwdata[MEM_AW-1:0];
        end else if (apb_access && paddr == REG_MEM_DATA && (!pwrite || pstrb[0])) begin
            mem_ptr_q <= mem_ptr_q + 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (wr_en && paddr == REG_MEM_DATA) begin
            mem[mem_ptr_q] <= pwdata[7:0];
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    a_wide_cmd_len: assert property (instr_done && cmd_word == CMD_DOUBLE_RATE_READ_WIDE
        |=> addr_len_q == ADDR_BITS_WIDE && state_q == ST_ADDR) else $error("wide read length wrong");
    a_narrow_cmd_len: assert property (instr_done && cmd_word == CMD_DOUBLE_RATE_READ
        |=> addr_len_q == ($past(cfg_q.wide_address_select) ? ADDR_BITS_WIDE : ADDR_BITS_NARROW))
        else $error("narrow read length wrong");
    a_ddr_addr_edge: assert property ((state_q == ST_ADDR) && fall_act && !need_rise_q && !addr_done
        |=> bit_cnt_q == $past(bit_cnt_q) + 6'h01) else $error("falling edge not taken");
    a_basic_no_mode: assert property (addr_done && !cfg_q.enhanced_latency_table && !cs_s
        |=> state_q == ST_DUMMY) else $error("mode phase with basic table");
    a_enh_mode: assert property (addr_done && cfg_q.enhanced_latency_table && !cs_s
        |=> state_q == ST_MODE) else $error("mode phase skipped");
    a_quiet_latency: assert property ((state_q == ST_DUMMY) && !launch_pre && !drive_q
        |=> so_oe_n) else $error("SO driven in latency");
    a_preamble_bits: assert property (launch_pre && !cs_s
        |=> !so_oe_n && so_out == $past(pattern_q[~pre_pos])) else $error("preamble bit wrong");
    a_data_msb: assert property (data_edge && !cs_s
        |=> so_out == $past(rd_byte[~bit_cnt_q[2:0]])) else $error("data bit order wrong");
    a_addr_step: assert property (data_edge && bit_cnt_q[2:0] == 3'b111
        |=> addr_q == (($past(addr_q) == ADDR_TOP) ? 32'h0000_0000 : $past(addr_q) + 32'h0000_0001))
        else $error("address step wrong");
    a_cont_exit: assert property (cs_rise && !(mode_done_q && mode_comp)
        |=> !cont_q) else $error("continuous mode kept");
    a_short_exit: assert property (cs_rise && (state_q == ST_ADDR)
        |=> !cont_q) else $error("short frame kept mode");
    a_cont_skip: assert property (cont_q && cs_fall
        |=> state_q == ST_ADDR) else $error("instruction expected in continuous mode");
    a_hold_masked: assert property (busy |=> !hold_pause) else $error("hold acted in read");

    c_cont_entry: cover property (cs_rise && mode_done_q && mode_comp);
    c_preamble: cover property (launch_pre);
    c_addr_wrap: cover property (data_edge && bit_cnt_q[2:0] == 3'b111 && addr_q == ADDR_TOP);
    c_wide_read: cover property (instr_done && cmd_word == CMD_DOUBLE_RATE_READ_WIDE);

endmodule

//--- testbench/dfrs_host_model.sv
// Host side of the single-bit double-rate link: drives frames, captures SO.
// Assumes the bench calls frame() and that SCK idles high between frames.
`timescale 1ns/1ps

module dfrs_host_model
    import dfrs_pkg::*;
(
    // Link driven by the host
    output logic cs_n,
    output logic sck,
    output logic si,
    // Device outputs
    input wire logic so_out,
    input wire logic so_oe_n,
    input wire logic hold_pause
);
    logic [7:0] pre_q;
    logic [31:0] data_q;
    logic bad_q;

    initial begin
        cs_n = 1'b1;
        sck = 1'b1;
        si = 1'b1;
        bad_q = 1'b0;
    end

    // One SCK half period; SO is sampled late because the pins pass synchronisers
    task automatic half(input logic b, output logic s);
        si = b;
        #20 sck = ~sck;
        #42.5 s = so_out;
    endtask

    task automatic frame(input bit ie, input logic [7:0] ins, input int ab, input logic [31:0] ad,
                         input bit me, input logic [7:0] md, input int dm, input int nb);
        logic s;
        data_q = '0;
        cs_n = 1'b0;
        #40;
        for (int i = 7; i >= 0 && ie; i--) begin
            half(ins[i], s);
            half(ins[i], s);
        end
        // Falling edge before the address carries nothing
        half(1'b0, s);
        for (int i = ab - 1; i >= 0; i--) begin
            half(ad[i], s);
            bad_q |= !so_oe_n;
        end
        for (int i = 7; i >= 0 && me; i--)
            half(md[i], s);
        // SI is released here, so it toggles rather than holding a value
        for (int i = 0; i < dm; i++) begin
            half(~si, s);
            pre_q = {pre_q[6:0], s};
        end
        for (int i = 0; i < 8 * nb; i++) begin
            half(~si, s);
            data_q = {data_q[30:0], s};
            bad_q |= so_oe_n | hold_pause;
        end
        cs_n = 1'b1;
        si = ~si;
        #40 sck = 1'b1;
        #200;
    endtask
endmodule

//--- testbench/ddr_fast_read_sequencer_tb.sv
// Self-checking bench for the double-rate fast read sequencer.
// Assumes zero-wait APB and the host model on the serial pins.
`timescale 1ns/1ps

module ddr_fast_read_sequencer_tb
    import dfrs_pkg::*;
;
    typedef struct {
        bit ie;
        logic [7:0] ins;
        bit wide, enh, pre;
        logic [7:0] md;
        logic [3:0] lc;
        logic [31:0] ad;
        int nb;
    } dfrs_row_s;

    logic clk_sys = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, hold_n = 1'b1;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [3:0] pstrb = 4'hF;
    wire logic pready, pslverr, so_out, so_oe_n, hold_pause, cs_n, sck, si;
    wire logic [31:0] prdata;
    logic [31:0] rd;
    logic err;
    int fail_count = 0, n_checks = 0, abits = 24;
    dfrs_row_s rows[8] = '{
        '{1, CMD_DOUBLE_RATE_READ, 0, 0, 0, 8'h00, 4'h0, 32'h0012_34FE, 4},
        '{1, CMD_DOUBLE_RATE_READ, 1, 0, 0, 8'h00, 4'h2, 32'hAB00_00FC, 2},
        '{1, CMD_DOUBLE_RATE_READ_WIDE, 0, 0, 0, 8'h00, 4'h1, 32'h0000_0001, 3},
        '{1, CMD_DOUBLE_RATE_READ, 0, 1, 1, 8'h00, 4'h3, 32'h0000_0002, 2},
        '{1, CMD_DOUBLE_RATE_READ, 0, 1, 0, 8'h5A, 4'h0, 32'h0000_00FF, 2},
        '{0, 8'h00, 0, 1, 0, 8'hA5, 4'h1, 32'h0000_0002, 2},
        '{0, 8'h00, 0, 1, 1, 8'h0F, 4'h3, 32'h0000_00FD, 4},
        '{0, 8'h00, 0, 1, 0, 8'h77, 4'h0, 32'h0000_0000, 1}};

    always #5 clk_sys = ~clk_sys;

    dfrs_core dfrs_core_inst (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n), .so_out(so_out),
        .so_oe_n(so_oe_n), .hold_pause(hold_pause));
    dfrs_host_model dfrs_host_model_inst (.cs_n(cs_n), .sck(sck), .si(si), .so_out(so_out),
        .so_oe_n(so_oe_n), .hold_pause(hold_pause));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL %0t %s: seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        // A slave that never answers counts against the run
        if (pready !== 1'b1) begin
            fail_count++;
            $display("FAIL %0t APB transfer not answered", $time);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Array contents chosen so that neighbouring bytes always differ
    function automatic logic [7:0] mv(input logic [7:0] a);
        return a ^ 8'h5C;
    endfunction

    task automatic run_row(input dfrs_row_s r);
        dfrs_cfg_s cfg;
        logic [31:0] exp;
        cfg = '{latency_code_field: r.lc, preamble_en: r.pre, enhanced_latency_table: r.enh,
                wide_address_select: r.wide};
        if (r.ie)
            abits = (r.wide || r.ins == CMD_DOUBLE_RATE_READ_WIDE) ? 32 : 24;
        exp = '0;
        for (int j = 0; j < r.nb; j++)
            exp = {exp[23:0], mv(r.ad[7:0] + 8'(j))};
        apb(1'b1, REG_CONFIG, 32'(cfg));
        apb(1'b1, REG_PATTERN, 32'h0000_00C9);
        dfrs_host_model_inst.frame(r.ie, r.ins, abits, r.ad, r.enh, r.md, 2 * (r.lc + 1), r.nb);
        check(dfrs_host_model_inst.data_q, exp, "read data");
        if (r.pre)
            check(dfrs_host_model_inst.pre_q, 32'h0000_00C9, "preamble");
        check(dfrs_host_model_inst.bad_q, 1'b0, "output enable or hold");
        apb(1'b0, REG_STATUS, '0);
        check(rd[0], r.enh && r.md[7:4] == ~r.md[3:0], "continuous mode");
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        check(so_oe_n, 1'b1, "idle output enable");
        apb(1'b0, REG_CONFIG, '0);
        check(rd, 32'(CFG_RESET), "config reset");
        apb(1'b0, REG_PATTERN, '0);
        check(rd, 32'(PATTERN_RESET), "pattern reset");
        apb(1'b0, 8'h40, '0);
        check({err, rd}, {1'b1, 32'h0}, "unmapped read");
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, REG_MEM_PTR, 32'(8'hFC + 8'(i)));
            apb(1'b1, REG_MEM_DATA, 32'(mv(8'hFC + 8'(i))));
        end
        $display("reset and preload done");
        // Hold requested through the eight rows: it must not disturb any of their reads
        hold_n <= 1'b0;
        foreach (rows[i]) begin
            run_row(rows[i]);
            $display("row %0d done", i);
        end
        repeat (10) @(posedge clk_sys);
        check(hold_pause, 1'b1, "hold while idle");
        hold_n <= 1'b1;
        run_row(rows[4]);
        dfrs_host_model_inst.frame(0, 8'h00, 0, '0, 0, 8'h00, 0, 0);
        apb(1'b0, REG_STATUS, '0);
        check(rd[0], 1'b0, "short frame exit");
        $display("short frame done");
        finish_test();
    end

    initial begin
        #800us;
        fail_count++;
        $display("FAIL %0t watchdog expired", $time);
        finish_test();
    end
endmodule
